// ---- hdl/ee_defines.svh ----
// Shared constants of the two-wire EEPROM link: framing, sizes, timing.
// Assumes both ends include it by bare name before their module headers.
// Behaviour
// - write control byte acknowledged when idle
// - two address bytes acknowledged, loaded into pointer
// - byte write; stop starts self-timed write
// - no acknowledge at all while writing
// - up to 32 bytes buffered, committed after stop
// - write data bumps only low five bits
// - over 32 bytes wrap, overwrite buffered bytes
// - polling control byte acknowledged once write finished
// - read control byte has read bit set
// - pointer keeps last accessed address plus one
// - read control acknowledged, then byte shifted out
// - repeated start aborts write, keeps pointer
// - master no-acknowledge: device releases data line
// - master acknowledge requests next sequential byte
// - read pointer increments after every byte
// - full pointer wraps from top to zero
// - control byte: type code, zero selects, rw
// - upper four address bits sent as zero
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH
// Device type code; the value is arbitrary.
`define EE_DEV_CODE 4'h6
`define EE_DEV_SEL 3'h0
`define EE_RW_READ 1'b1
`define EE_RW_WRITE 1'b0
`define EE_ADDR_W 12
`define EE_PAGE_W 5
`define EE_PAGE_BYTES 32
`define EE_ACK_BIT 4'h8
`define EE_END_BIT 4'h9
`define EE_HI_PAD 4'h0
`define EE_CLK_NS 25
`define EE_TWR_NS 5000000
`define EE_QTR_NS 100
`define EE_QTR_CYC (`EE_QTR_NS / `EE_CLK_NS)
`endif

// ---- hdl/ee_pkg.sv ----
// Types shared by both ends of the two-wire EEPROM link.
// Assumes nothing of its surroundings.
package ee_pkg;
  typedef enum logic [1:0] {
    EE_OP_WRITE, EE_OP_CUR, EE_OP_RAND, EE_OP_POLL
  } ee_op_t;
  typedef enum logic [2:0] {
    EE_D_IDLE, EE_D_CTRL, EE_D_AH, EE_D_AL, EE_D_WD, EE_D_RD, EE_D_IGN
  } ee_dst_t;
  typedef enum logic [1:0] {
    EE_H_IDLE, EE_H_START, EE_H_BYTE, EE_H_STOP
  } ee_hst_t;
  typedef enum logic [2:0] {
    EE_S_CW, EE_S_AH, EE_S_AL, EE_S_WD, EE_S_CR, EE_S_RD
  } ee_step_t;
endpackage

// ---- hdl/ee_link_if.sv ----
// Two-wire link between master and EEPROM slave.
// Assumes a pull-up: the data line is low only while an end pulls it.
`timescale 1ns/100ps
interface ee_link_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe_n;
  logic s_sda_out;
  logic s_sda_oe_n;
  logic sda;
  // Wired-AND of both open-drain drivers.
  assign sda = (m_sda_oe_n | m_sda_out) & (s_sda_oe_n | s_sda_out);
  modport master(output scl, output m_sda_out, output m_sda_oe_n,
                 input sda);
  modport slave(input scl, input sda, output s_sda_out,
                output s_sda_oe_n);
endinterface

// ---- hdl/ee_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/100ps
module ee_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW:0] wp_q, rp_q;
  logic push, pop;

  // Pointers carry one extra bit so full and empty are told apart.
  assign in_ready_out = (wp_q ^ rp_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_out = wp_q != rp_q;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_q[rp_q[AW-1:0]];

  // Storage needs no reset; empty pointers hide stale words.
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data_in;
    end
  end

  // Pointer update.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule // ee_fifo

// ---- hdl/ee_slave.sv ----
// EEPROM end of the two-wire link: command decode, page buffer,
// self-timed write and array.
// Assumes the master drives the clock; both pins are sampled here.
`timescale 1ns/100ps
`include "ee_defines.svh"
module ee_slave import ee_pkg::*; #(
  parameter int WR_CYC = `EE_TWR_NS / `EE_CLK_NS
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  ee_link_if.slave link,
  output logic busy_out
);
  localparam int AW = `EE_ADDR_W;
  localparam int PW = `EE_PAGE_W;

  // ----------------------------------------------------------------
  // Pin sampling and bus events
  // ----------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_p_q;
  logic sda_s1_q, sda_s2_q, sda_p_q;
  logic rise, fall, start, stop;

  // Two flops per pin, then a third stage for edge detection.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s1_q <= link.scl;
      scl_s2_q <= scl_s1_q;
      scl_p_q <= scl_s2_q;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
      sda_p_q <= sda_s2_q;
    end
  end

  // Data edges while the clock stays high frame a transfer.
  assign rise = scl_s2_q & ~scl_p_q;
  assign fall = ~scl_s2_q & scl_p_q;
  assign start = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  ee_dst_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q, tx_q, rd_byte;
  logic mack_q, sda_low_q, busy_q, ctrl_ok, ack_this;
  logic byte_done, wr_go, wr_done;
  logic [AW-1:0] ptr_q;
  logic [7:0] mem_q [0:(1<<AW)-1];
  logic [7:0] page_q [0:`EE_PAGE_BYTES-1];
  logic [`EE_PAGE_BYTES-1:0] pend_q;
  logic [AW-PW-1:0] base_q;
  logic [31:0] wcnt_q;

  assign rd_byte = mem_q[ptr_q];
  assign byte_done = fall && cnt_q == `EE_ACK_BIT;
  assign ctrl_ok = sh_q[7:1] == {`EE_DEV_CODE, `EE_DEV_SEL};

  // Acknowledge decision at the end of each received byte.
  always_comb begin
    case (st_q)
      EE_D_CTRL: ack_this = ctrl_ok & ~busy_q;
      EE_D_AH, EE_D_AL, EE_D_WD: ack_this = 1'b1;
      default: ack_this = 1'b0;
    endcase
  end

  // Bit counter, shifting, and the data line drive.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= EE_D_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      mack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start) begin
      st_q <= EE_D_CTRL;
      cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop) begin
      st_q <= EE_D_IDLE;
      cnt_q <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (st_q != EE_D_IDLE && st_q != EE_D_IGN) begin
      if (rise) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q < `EE_ACK_BIT) begin
          sh_q <= {sh_q[6:0], sda_s2_q};
        end else begin
          mack_q <= ~sda_s2_q;
        end
      end
      if (fall) begin
        if (cnt_q == `EE_ACK_BIT) begin
          if (st_q == EE_D_RD) begin
            sda_low_q <= 1'b0;
          end else if (ack_this) begin
            sda_low_q <= 1'b1;
          end else begin
            st_q <= EE_D_IGN;
          end
        end else if (cnt_q == `EE_END_BIT) begin
          cnt_q <= 4'h0;
          sda_low_q <= 1'b0;
          case (st_q)
            EE_D_CTRL: begin
              if (sh_q[0] == `EE_RW_READ) begin
                st_q <= EE_D_RD;
                tx_q <= rd_byte;
                sda_low_q <= ~rd_byte[7];
              end else begin
                st_q <= EE_D_AH;
              end
            end
            EE_D_AH: st_q <= EE_D_AL;
            EE_D_AL: st_q <= EE_D_WD;
            EE_D_RD: begin
              if (mack_q) begin
                tx_q <= rd_byte;
                sda_low_q <= ~rd_byte[7];
              end else begin
                st_q <= EE_D_IGN;
              end
            end
            default: st_q <= st_q;
          endcase
        end else if (st_q == EE_D_RD && cnt_q != 4'h0) begin
          sda_low_q <= ~tx_q[3'd7 - cnt_q[2:0]];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Address pointer
  // ----------------------------------------------------------------
  // Write data moves only the in-page bits; reads move all twelve.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_q <= '0;
    end else if (byte_done) begin
      case (st_q)
        EE_D_AH: ptr_q[AW-1:8] <= sh_q[AW-9:0];
        EE_D_AL: ptr_q[7:0] <= sh_q;
        EE_D_WD: ptr_q[PW-1:0] <= ptr_q[PW-1:0] + 1'b1;
        EE_D_RD: ptr_q <= ptr_q + 1'b1;
        default: ptr_q <= ptr_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Page buffer and self-timed write
  // ----------------------------------------------------------------
  assign wr_go = stop && st_q == EE_D_WD && (|pend_q);
  assign wr_done = busy_q && wcnt_q == 32'(WR_CYC - 1);

  // Buffered bytes land by in-page index; a wrap overwrites.
  always_ff @(posedge core_clk_in) begin
    if (byte_done && st_q == EE_D_WD) begin
      page_q[ptr_q[PW-1:0]] <= sh_q;
      base_q <= ptr_q[AW-1:PW];
    end
  end

  // Which buffer entries hold data; a repeated start discards them.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_q <= '0;
    end else if (byte_done && st_q == EE_D_WD) begin
      pend_q[ptr_q[PW-1:0]] <= 1'b1;
    end else if ((start && st_q == EE_D_WD) || wr_done) begin
      pend_q <= '0;
    end
  end

  // Write timer; requires WR_CYC of at least one page of cycles.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_q <= 1'b0;
      wcnt_q <= 32'h0;
    end else if (wr_go) begin
      busy_q <= 1'b1;
      wcnt_q <= 32'h0;
    end else if (busy_q) begin
      wcnt_q <= wcnt_q + 32'h1;
      if (wr_done) busy_q <= 1'b0;
    end
  end

  // Commit one buffered byte per cycle at the start of the cycle.
  always_ff @(posedge core_clk_in) begin
    if (busy_q && wcnt_q < `EE_PAGE_BYTES && pend_q[wcnt_q[PW-1:0]]) begin
      mem_q[{base_q, wcnt_q[PW-1:0]}] <= page_q[wcnt_q[PW-1:0]];
    end
  end

  assign link.s_sda_out = 1'b0;
  assign link.s_sda_oe_n = ~sda_low_q;
  assign busy_out = busy_q;
endmodule // ee_slave

// ---- hdl/ee_master.sv ----
// Master end of the two-wire link: runs whole EEPROM commands.
// Assumes one command at a time; write data arrives through a FIFO.
`timescale 1ns/100ps
`include "ee_defines.svh"
module ee_master import ee_pkg::*; #(
  parameter int LEN_W = 13,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  ee_link_if.master link,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire ee_op_t cmd_op_in,
  input wire logic [`EE_ADDR_W-1:0] cmd_addr_in,
  input wire logic [LEN_W-1:0] cmd_len_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic fail_out
);
  ee_hst_t hs_q;
  ee_step_t step_q;
  ee_op_t op_q;
  logic [`EE_ADDR_W-1:0] addr_q;
  logic [LEN_W-1:0] rem_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q, rx_q, load_byte, f_data;
  logic [7:0] qc_q;
  logic tick, stall, f_valid, f_pop, rx, more;
  logic ack_ok_q, scl_q, sda_low_q, sda_s1_q, sda_s2_q;

  // Write data buffer; an empty buffer stalls the clock low.
  ee_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .in_data_in(wr_data_in),
    .out_valid_out(f_valid),
    .out_ready_in(f_pop),
    .out_data_out(f_data)
  );

  // Quarter-bit tick divides the core clock into the link clock.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) qc_q <= 8'h00;
    else if (tick) qc_q <= 8'h00;
    else qc_q <= qc_q + 8'h01;
  end
  assign tick = qc_q == 8'(`EE_QTR_CYC - 1);

  // Data line is foreign to this clock: two flops.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  // Byte to send for the current step.
  always_comb begin
    case (step_q)
      EE_S_CW: load_byte = {`EE_DEV_CODE, `EE_DEV_SEL, `EE_RW_WRITE};
      EE_S_CR: load_byte = {`EE_DEV_CODE, `EE_DEV_SEL, `EE_RW_READ};
      EE_S_AH: load_byte = {`EE_HI_PAD, addr_q[`EE_ADDR_W-1:8]};
      EE_S_AL: load_byte = addr_q[7:0];
      default: load_byte = f_data;
    endcase
  end

  assign rx = step_q == EE_S_RD;
  assign more = rem_q > LEN_W'(1);
  assign stall = hs_q == EE_H_BYTE && ph_q == 2'h0 && bit_q == 4'h0 &&
                 step_q == EE_S_WD && !f_valid;
  assign f_pop = tick && hs_q == EE_H_BYTE && ph_q == 2'h0 &&
                 bit_q == 4'h0 && step_q == EE_S_WD && f_valid;
  assign cmd_ready_out = hs_q == EE_H_IDLE;

  // Command sequencer: start, bytes, stop, one quarter per phase.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hs_q <= EE_H_IDLE;
      step_q <= EE_S_CW;
      op_q <= EE_OP_WRITE;
      addr_q <= '0;
      rem_q <= '0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      ack_ok_q <= 1'b0;
      scl_q <= 1'b1;
      sda_low_q <= 1'b0;
      fail_out <= 1'b0;
      done_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      rd_valid_out <= 1'b0;
      if (hs_q == EE_H_IDLE) begin
        if (cmd_valid_in) begin
          op_q <= cmd_op_in;
          addr_q <= cmd_addr_in;
          rem_q <= cmd_len_in;
          step_q <= (cmd_op_in == EE_OP_CUR) ? EE_S_CR : EE_S_CW;
          fail_out <= 1'b0;
          ph_q <= 2'h0;
          hs_q <= EE_H_START;
        end
      end else if (tick && !stall) begin
        ph_q <= ph_q + 2'h1;
        case (hs_q)
          EE_H_START: begin
            case (ph_q)
              2'h0: begin
                scl_q <= 1'b0;
                sda_low_q <= 1'b0;
              end
              2'h1: scl_q <= 1'b1;
              2'h2: sda_low_q <= 1'b1;
              default: begin
                scl_q <= 1'b0;
                bit_q <= 4'h0;
                hs_q <= EE_H_BYTE;
              end
            endcase
          end
          EE_H_BYTE: begin
            case (ph_q)
              2'h0: begin
                if (bit_q == `EE_ACK_BIT) begin
                  sda_low_q <= rx & more;
                end else if (rx) begin
                  sda_low_q <= 1'b0;
                end else if (bit_q == 4'h0) begin
                  tx_q <= load_byte;
                  sda_low_q <= ~load_byte[7];
                end else begin
                  sda_low_q <= ~tx_q[3'd7 - bit_q[2:0]];
                end
              end
              2'h1: scl_q <= 1'b1;
              2'h2: begin
                if (bit_q == `EE_ACK_BIT) ack_ok_q <= ~sda_s2_q;
                else rx_q <= {rx_q[6:0], sda_s2_q};
              end
              default: begin
                scl_q <= 1'b0;
                bit_q <= (bit_q == `EE_ACK_BIT) ? 4'h0 : bit_q + 4'h1;
                if (bit_q == `EE_ACK_BIT) begin
                  if (!rx && !ack_ok_q) begin
                    fail_out <= 1'b1;
                    hs_q <= EE_H_STOP;
                  end else begin
                    case (step_q)
                      EE_S_CW: begin
                        if (op_q == EE_OP_POLL) hs_q <= EE_H_STOP;
                        else step_q <= EE_S_AH;
                      end
                      EE_S_AH: step_q <= EE_S_AL;
                      EE_S_AL: begin
                        if (op_q == EE_OP_RAND) begin
                          step_q <= EE_S_CR;
                          hs_q <= EE_H_START;
                        end else if (rem_q == '0) begin
                          hs_q <= EE_H_STOP;
                        end else begin
                          step_q <= EE_S_WD;
                        end
                      end
                      EE_S_WD: begin
                        rem_q <= rem_q - LEN_W'(1);
                        if (!more) hs_q <= EE_H_STOP;
                      end
                      EE_S_CR: step_q <= EE_S_RD;
                      default: begin
                        rd_data_out <= rx_q;
                        rd_valid_out <= 1'b1;
                        rem_q <= rem_q - LEN_W'(1);
                        if (!more) hs_q <= EE_H_STOP;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          EE_H_STOP: begin
            case (ph_q)
              2'h0: sda_low_q <= 1'b1;
              2'h1: scl_q <= 1'b1;
              2'h2: sda_low_q <= 1'b0;
              default: begin
                hs_q <= EE_H_IDLE;
                done_out <= 1'b1;
              end
            endcase
          end
          default: hs_q <= EE_H_IDLE;
        endcase
      end
    end
  end

  assign link.scl = scl_q;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe_n = ~sda_low_q;
endmodule // ee_master

// ---- testbench/ee_link_asserts.sv ----
// Assertions on the two-wire link that joins the two EEPROM ends.
// Assumes the bench places it beside the link interface.
`timescale 1ns/100ps
module ee_link_asserts #(
  parameter int WR_CYC = 64
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic scl,
  input wire logic m_sda_out,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_out,
  input wire logic s_sda_oe_n,
  input wire logic sda,
  input wire logic busy_out
);
  // ----
  // Helper logic
  // ----
  logic [31:0] busy_cnt_q;
  // Length of the running write cycle; a one-cycle slack is allowed.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_out ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // A STOP is a data rise while the clock stays high.
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  // The clock pulse that carries a bit the slave has put out.
  sequence pulse_s;
    ##[1:16] $rose(scl) ##[1:16] $fell(scl);
  endsequence
  slave_stable_a: assert property (
    $changed(s_sda_oe_n) |-> !scl && !$past(scl))
    else $error("slave data moved while clock high");
  busy_quiet_a: assert property (busy_out |-> s_sda_oe_n)
    else $error("slave pulled data while writing");
  stop_release_a: assert property (
    stop_s |=> s_sda_oe_n [*8])
    else $error("slave held data after stop");
  ack_hold_a: assert property (
    $fell(s_sda_oe_n) |-> !s_sda_oe_n throughout pulse_s)
    else $error("slave pull not held over its pulse");
  busy_start_a: assert property ($rose(busy_out) |-> scl && sda)
    else $error("write cycle began on a busy line");
  busy_len_a: assert property (
    $fell(busy_out) |-> busy_cnt_q >= WR_CYC - 1 &&
      busy_cnt_q <= WR_CYC + 1)
    else $error("write cycle length wrong");
  clock_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  master_yield_a: assert property (
    scl && !s_sda_oe_n |-> m_sda_oe_n)
    else $error("master pulled data during slave bit");
  drive_zero_a: assert property (!m_sda_out && !s_sda_out)
    else $error("open-drain value not low");
  // Ack plus one data byte is the longest pull; longer means a hung slave.
  pull_bound_a: assert property (
    $fell(s_sda_oe_n) |-> ##[1:160] $rose(s_sda_oe_n))
    else $error("slave kept data line pulled too long");
endmodule // ee_link_asserts

// ---- testbench/tb_serial_eeprom_rw_protocol.sv ----
// Bench joining master and EEPROM ends across the link interface.
// Assumes the design files and the checker compile first.
`timescale 1ns/100ps
module tb_serial_eeprom_rw_protocol import ee_pkg::*;;
  localparam int WR_CYC = 400;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  ee_op_t cmd_op_in = EE_OP_CUR;
  logic [11:0] cmd_addr_in = 12'h000;
  logic [12:0] cmd_len_in = 13'h0000;
  logic wr_valid_in = 1'b0;
  logic [7:0] wr_data_in = 8'h00;
  logic cmd_ready_out, wr_ready_out, rd_valid_out, done_out, fail_out;
  logic busy_out, fail_seen;
  logic [7:0] rd_data_out;
  logic [7:0] rd_q[$];
  logic [7:0] exp_mem [0:4095];
  int error_cnt = 0;
  int samples_checked = 0;
  // ----
  // Design ends and checker
  // ----
  ee_link_if i_ee_link_if();
  ee_master i_ee_master(.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .link(i_ee_link_if), .cmd_valid_in(cmd_valid_in),
    .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in),
    .cmd_addr_in(cmd_addr_in), .cmd_len_in(cmd_len_in),
    .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out),
    .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .done_out(done_out),
    .fail_out(fail_out));
  ee_slave #(.WR_CYC(WR_CYC)) i_ee_slave(.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .link(i_ee_link_if), .busy_out(busy_out));
  ee_link_asserts #(.WR_CYC(WR_CYC)) i_ee_link_asserts(
    .core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .scl(i_ee_link_if.scl), .m_sda_out(i_ee_link_if.m_sda_out),
    .m_sda_oe_n(i_ee_link_if.m_sda_oe_n),
    .s_sda_out(i_ee_link_if.s_sda_out),
    .s_sda_oe_n(i_ee_link_if.s_sda_oe_n), .sda(i_ee_link_if.sda),
    .busy_out(busy_out));
  // A 40 MHz clock; the link clock comes from the master's divider.
  always #12.5 core_clk_in = ~core_clk_in;
  // Read bytes pulse for one cycle only, so they are caught here, half a
  // cycle after launch, so the byte has settled.
  always @(negedge core_clk_in) begin
    if (rd_valid_out === 1'b1) begin
      rd_q.push_back(rd_data_out);
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatched %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Offers one command, then waits for its done pulse under a bound.
  task automatic run_cmd(input ee_op_t op, input logic [11:0] addr,
                         input logic [12:0] len);
    int n;
    @(negedge core_clk_in);
    while (cmd_ready_out !== 1'b1) @(negedge core_clk_in);
    rd_q.delete();
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_addr_in = addr;
    cmd_len_in = len;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
    for (n = 0; n < 20000 && done_out !== 1'b1; n++) begin
      @(negedge core_clk_in);
    end
    check({7'h0, done_out}, 8'h01);
    fail_seen = fail_out;
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge core_clk_in);
    while (wr_ready_out !== 1'b1) @(negedge core_clk_in);
    wr_valid_in = 1'b1;
    wr_data_in = d;
    @(negedge core_clk_in);
    wr_valid_in = 1'b0;
  endtask
  // Writes n bytes base+i; pre of them are queued before the command.
  task automatic wr_cmd(input logic [11:0] addr, input int n,
                        input logic [7:0] base, input int pre);
    int k;
    for (k = 0; k < pre; k++) push(base + 8'(k));
    if (pre == 32) check({7'h0, wr_ready_out}, 8'h00);
    fork
      run_cmd(EE_OP_WRITE, addr, 13'(n));
      for (k = pre; k < n; k++) push(base + 8'(k));
    join
    check({7'h0, fail_seen}, 8'h00);
    for (k = 0; k < n; k++) begin
      exp_mem[{addr[11:5], addr[4:0] + 5'(k)}] = base + 8'(k);
    end
    run_cmd(EE_OP_POLL, 12'h000, 13'h0000);
    check({7'h0, fail_seen}, {7'h0, n > 0});
    for (k = 0; k < 30 && fail_seen !== 1'b0; k++) begin
      run_cmd(EE_OP_POLL, 12'h000, 13'h0000);
    end
    check({7'h0, fail_seen}, 8'h00);
  endtask
  task automatic read_chk(input ee_op_t op, input logic [11:0] addr,
                          input int n);
    int k;
    run_cmd(op, addr, 13'(n));
    check(8'(rd_q.size()), 8'(n));
    for (k = 0; k < n && k < rd_q.size(); k++) begin
      check(rd_q[k], exp_mem[addr + 12'(k)]);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic scn_byte();
    wr_cmd(12'h400, 1, 8'ha5, 0);
    read_chk(EE_OP_RAND, 12'h400, 1);
  endtask
  // Fills the buffer to refusal, then runs past the page and wraps.
  task automatic scn_page();
    wr_cmd(12'h3fc, 36, 8'h40, 32);
    read_chk(EE_OP_RAND, 12'h3e0, 33);
  endtask
  task automatic scn_top();
    wr_cmd(12'h000, 2, 8'h33, 0);
    wr_cmd(12'hfff, 2, 8'h11, 0);
    read_chk(EE_OP_RAND, 12'hfff, 2);
    read_chk(EE_OP_CUR, 12'h001, 1);
  endtask
  // An address-only write moves the pointer and starts no write.
  task automatic scn_addr_only();
    wr_cmd(12'h3e5, 0, 8'h00, 0);
    read_chk(EE_OP_CUR, 12'h3e5, 1);
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rstn_in = 1'b1;
    scn_byte();
    scn_page();
    scn_top();
    scn_addr_only();
    results();
  end
  // The tests take about 19,000 core cycles; this allows about twice that.
  initial begin
    #1000000;
    error_cnt++;
    results();
  end
endmodule // tb_serial_eeprom_rw_protocol
